/* core/cise_pkg.sv */
package cise_pkg;
   // Word indices on the Avalon address bus
   localparam logic [3:0] OFS_INSTR = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_WORK = 4'h2;
   localparam logic [3:0] OFS_PC = 4'h3;
   localparam logic [3:0] OFS_PC_HIGH_LATCH = 4'h4;
   localparam logic [3:0] OFS_STACK_TOP = 4'h5;
   localparam logic [3:0] OFS_WATCHDOG = 4'h6;
   localparam logic [3:0] OFS_FILE_PTR = 4'h7;
   localparam logic [3:0] OFS_FILE_DATA = 4'h8;

   // Status register fields
   localparam int ST_ZERO_BIT = 0;
   localparam int ST_POWER_DOWN_BIT = 1;
   localparam int ST_TIMEOUT_BIT = 2;
   localparam int ST_BUSY_BIT = 3;

   // Reset values
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;
   localparam logic TIMEOUT_RST = 1'b1;
   localparam logic POWER_DOWN_RST = 1'b1;

   // Instruction word and fields
   localparam int INSTR_W = 14;
   localparam int FILE_AW = 7;
   localparam int FILE_DEPTH = 128;
   localparam int DEST_BIT = 7;
   localparam int CALL_HI_SRC = 4;
   localparam int CALL_LO_SRC = 3;
   localparam logic [INSTR_W-1:0] OPC_WATCHDOG_CLEAR = 14'h0064;
   localparam logic [INSTR_W-1:0] MSK_NO_DEST = 14'h3F80;
   localparam logic [INSTR_W-1:0] OPC_CLEAR_WORK = 14'h0100;
   localparam logic [INSTR_W-1:0] OPC_CLEAR_REG = 14'h0180;
   localparam logic [INSTR_W-1:0] MSK_DEST = 14'h3F00;
   localparam logic [INSTR_W-1:0] OPC_COMPLEMENT = 14'h0900;
   localparam logic [INSTR_W-1:0] OPC_DECREMENT = 14'h0300;
   localparam logic [INSTR_W-1:0] OPC_DEC_SKIP = 14'h0B00;
   localparam logic [INSTR_W-1:0] MSK_CALL = 14'h3800;
   localparam logic [INSTR_W-1:0] OPC_CALL = 14'h2000;

   // Watchdog values
   localparam logic [7:0] WATCHDOG_CLEAR_VAL = 8'h00;
   localparam logic [7:0] WATCHDOG_PRE_LAST = 8'hFF;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SECOND,
      ST_BUS_RD
   } cise_state_t;

   typedef struct packed {
      cise_state_t state;
      logic [INSTR_W-1:0] instr;
      logic [7:0] work;
      logic zero;
      logic power_down_flag;
      logic timeout_flag;
      logic [12:0] pc;
      logic [4:0] pc_high_latch;
      logic [12:0] stack_top;
      logic [7:0] watchdog_counter;
      logic [7:0] watchdog_pre;
      logic [FILE_AW-1:0] fptr;
      logic skip_pending;
      logic waitreq;
      logic [31:0] rdata;
      logic push;
      logic watchdog_clr;
   } cise_regs_t;
endpackage

/* core/cise_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cise_mem_if;
   import cise_pkg::*;
   logic we;
   logic [FILE_AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output we, addr, wdata, input rdata);
   modport mem (input we, addr, wdata, output rdata);
endinterface

interface cise_alu_if;
   import cise_pkg::*;
   logic [INSTR_W-1:0] instr;
   logic [7:0] fdata;
   logic [7:0] result;
   logic wr_file;
   logic wr_work;
   logic upd_z;
   logic z_val;
   logic skip;
   logic call;
   logic watchdog_clr;
   modport ctrl (output instr, fdata,
                 input result, wr_file, wr_work, upd_z, z_val, skip, call, watchdog_clr);
   modport unit (input instr, fdata,
                 output result, wr_file, wr_work, upd_z, z_val, skip, call, watchdog_clr);
endinterface
`default_nettype wire

/* core/cise_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module cise_mem
   import cise_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   cise_mem_if.mem port
);
   logic [7:0] cells [FILE_DEPTH];
   logic [7:0] rdata_reg;

   // Read before write: same-address access returns the old byte
   always_ff @(posedge clk) begin
      if (port.we) begin
         cells[port.addr] <= port.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= cells[port.addr];
      end
   end

   assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

/* core/cise_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module cise_alu
   import cise_pkg::*;
(
   cise_alu_if.unit port
);
   logic dest;

   always_comb begin
      dest = port.instr[DEST_BIT];
      port.result = 8'h00;
      port.wr_file = 1'b0;
      port.wr_work = 1'b0;
      port.upd_z = 1'b0;
      port.z_val = 1'b0;
      port.skip = 1'b0;
      port.call = 1'b0;
      port.watchdog_clr = 1'b0;
      if (port.instr == OPC_WATCHDOG_CLEAR) begin
         port.watchdog_clr = 1'b1;
      end else if ((port.instr & MSK_CALL) == OPC_CALL) begin
         port.call = 1'b1;
      end else if ((port.instr & MSK_NO_DEST) == OPC_CLEAR_WORK) begin
         port.wr_work = 1'b1;
         port.upd_z = 1'b1;
         port.z_val = 1'b1;
      end else if ((port.instr & MSK_NO_DEST) == OPC_CLEAR_REG) begin
         port.wr_file = 1'b1;
         port.upd_z = 1'b1;
         port.z_val = 1'b1;
      end else if ((port.instr & MSK_DEST) == OPC_COMPLEMENT) begin
         port.result = ~port.fdata;
         port.wr_file = dest;
         port.wr_work = !dest;
         port.upd_z = 1'b1;
         port.z_val = (port.result == 8'h00);
      end else if ((port.instr & MSK_DEST) == OPC_DECREMENT) begin
         port.result = port.fdata - 8'h01;
         port.wr_file = dest;
         port.wr_work = !dest;
         port.upd_z = 1'b1;
         port.z_val = (port.result == 8'h00);
      end else if ((port.instr & MSK_DEST) == OPC_DEC_SKIP) begin
         port.result = port.fdata - 8'h01;
         port.wr_file = dest;
         port.wr_work = !dest;
         port.skip = (port.result == 8'h00);
      end
   end
endmodule
`default_nettype wire

/* core/cise_core.sv */
`timescale 1ns/1ps
`default_nettype none
module cise_core
   import cise_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   output logic [12:0] STACK_TOP_OUT,
   output logic STACK_PUSH_OUT,
   output logic WATCHDOG_CLEAR_OUT
);
   cise_regs_t r_reg;
   cise_regs_t r_next;
   logic accept;
   logic [31:0] lane_mask;
   logic [31:0] wd;
   logic [31:0] rd_word;

   cise_mem_if mif ();
   cise_alu_if aif ();

   cise_mem u_file (
      .clk(CLK_IN),
      .rst_n(RSTN_IN),
      .port(mif.mem)
   );

   cise_alu u_alu (
      .port(aif.unit)
   );

   assign wd = AVS_WRITEDATA_IN;
   assign lane_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                       {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

   // Only one access at a time; a busy core simply holds waitrequest
   assign accept = (AVS_READ_IN || AVS_WRITE_IN) && r_reg.waitreq && (r_reg.state == ST_IDLE);

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (AVS_ADDRESS_IN)
         OFS_INSTR: rd_word = {18'h00000, r_reg.instr};
         OFS_STATUS: begin
            rd_word[ST_ZERO_BIT] = r_reg.zero;
            rd_word[ST_POWER_DOWN_BIT] = r_reg.power_down_flag;
            rd_word[ST_TIMEOUT_BIT] = r_reg.timeout_flag;
            rd_word[ST_BUSY_BIT] = (r_reg.state != ST_IDLE);
         end
         OFS_WORK: rd_word = {24'h000000, r_reg.work};
         OFS_PC: rd_word = {19'h00000, r_reg.pc};
         OFS_PC_HIGH_LATCH: rd_word = {27'h0000000, r_reg.pc_high_latch};
         OFS_STACK_TOP: rd_word = {19'h00000, r_reg.stack_top};
         OFS_WATCHDOG: rd_word = {16'h0000, r_reg.watchdog_pre, r_reg.watchdog_counter};
         OFS_FILE_PTR: rd_word = {25'h0000000, r_reg.fptr};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      r_next = r_reg;
      r_next.waitreq = 1'b1;
      r_next.push = 1'b0;
      r_next.watchdog_clr = 1'b0;
      mif.we = 1'b0;
      mif.addr = r_reg.fptr;
      mif.wdata = wd[7:0];
      aif.instr = r_reg.instr;
      aif.fdata = mif.rdata;

      // Free-running watchdog; its timeout action lives outside this core
      r_next.watchdog_pre = r_reg.watchdog_pre + 8'h01;
      if (r_reg.watchdog_pre == WATCHDOG_PRE_LAST) begin
         r_next.watchdog_counter = r_reg.watchdog_counter + 8'h01;
      end

      unique case (r_reg.state)
         ST_IDLE: begin
            if (accept && AVS_WRITE_IN) begin
               r_next.waitreq = 1'b0;
               unique case (AVS_ADDRESS_IN)
                  OFS_INSTR: begin
                     // Both low byte lanes needed to issue; writes missing either are ignored
                     if (AVS_BYTEENABLE_IN[1:0] == 2'b11) begin
                        r_next.instr = wd[INSTR_W-1:0];
                        mif.addr = wd[FILE_AW-1:0];
                        r_next.state = ST_EXEC;
                     end
                  end
                  OFS_STATUS: begin
                     if (AVS_BYTEENABLE_IN[0]) begin
                        r_next.zero = wd[ST_ZERO_BIT];
                        r_next.power_down_flag = wd[ST_POWER_DOWN_BIT];
                        r_next.timeout_flag = wd[ST_TIMEOUT_BIT];
                     end
                  end
                  OFS_WORK: begin
                     r_next.work = (r_reg.work & ~lane_mask[7:0]) | (wd[7:0] & lane_mask[7:0]);
                  end
                  OFS_PC: begin
                     r_next.pc = (r_reg.pc & ~lane_mask[12:0]) | (wd[12:0] & lane_mask[12:0]);
                  end
                  OFS_PC_HIGH_LATCH: begin
                     r_next.pc_high_latch = (r_reg.pc_high_latch & ~lane_mask[4:0])
                                            | (wd[4:0] & lane_mask[4:0]);
                  end
                  OFS_FILE_PTR: begin
                     r_next.fptr = (r_reg.fptr & ~lane_mask[FILE_AW-1:0])
                                   | (wd[FILE_AW-1:0] & lane_mask[FILE_AW-1:0]);
                  end
                  OFS_FILE_DATA: begin
                     mif.we = AVS_BYTEENABLE_IN[0];
                  end
                  default: begin
                  end
               endcase
            end else if (accept) begin
               if (AVS_ADDRESS_IN == OFS_FILE_DATA) begin
                  // Memory read data is one cycle late, so answer next cycle
                  r_next.state = ST_BUS_RD;
               end else begin
                  r_next.waitreq = 1'b0;
                  r_next.rdata = rd_word;
               end
            end
         end
         ST_EXEC: begin
            mif.addr = r_reg.instr[FILE_AW-1:0];
            mif.we = aif.wr_file;
            mif.wdata = aif.result;
            if (aif.wr_work) begin
               r_next.work = aif.result;
            end
            if (aif.upd_z) begin
               r_next.zero = aif.z_val;
            end
            r_next.pc = r_reg.pc + 13'h0001;
            r_next.state = ST_IDLE;
            if (aif.watchdog_clr) begin
               r_next.watchdog_counter = WATCHDOG_CLEAR_VAL;
               r_next.watchdog_pre = WATCHDOG_CLEAR_VAL;
               r_next.timeout_flag = 1'b1;
               r_next.power_down_flag = 1'b1;
               r_next.watchdog_clr = 1'b1;
            end
            if (aif.call) begin
               r_next.stack_top = r_reg.pc + 13'h0001;
               r_next.push = 1'b1;
               r_next.pc = {r_reg.pc_high_latch[CALL_HI_SRC:CALL_LO_SRC],
                            r_reg.instr[10:0]};
               r_next.skip_pending = 1'b0;
               r_next.state = ST_SECOND;
            end
            if (aif.skip) begin
               r_next.skip_pending = 1'b1;
               r_next.state = ST_SECOND;
            end
         end
         ST_SECOND: begin
            // Dead cycle: call refill, or discarded instruction run as no-op
            if (r_reg.skip_pending) begin
               r_next.pc = r_reg.pc + 13'h0001;
            end
            r_next.skip_pending = 1'b0;
            r_next.state = ST_IDLE;
         end
         ST_BUS_RD: begin
            r_next.waitreq = 1'b0;
            r_next.rdata = {24'h000000, mif.rdata};
            r_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         r_reg <= '{
            state: ST_IDLE,
            instr: 14'h0000,
            work: WORK_RST,
            zero: ZERO_RST,
            power_down_flag: POWER_DOWN_RST,
            timeout_flag: TIMEOUT_RST,
            pc: PC_RST,
            pc_high_latch: 5'h00,
            stack_top: 13'h0000,
            watchdog_counter: 8'h00,
            watchdog_pre: 8'h00,
            fptr: 7'h00,
            skip_pending: 1'b0,
            waitreq: 1'b1,
            rdata: 32'h0000_0000,
            push: 1'b0,
            watchdog_clr: 1'b0
         };
      end else begin
         r_reg <= r_next;
      end
   end

   assign AVS_READDATA_OUT = r_reg.rdata;
   assign AVS_WAITREQUEST_OUT = r_reg.waitreq;
   assign STACK_TOP_OUT = r_reg.stack_top;
   assign STACK_PUSH_OUT = r_reg.push;
   assign WATCHDOG_CLEAR_OUT = r_reg.watchdog_clr;
endmodule
`default_nettype wire

/* bench/cise_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cise_core_properties
   import cise_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   input wire logic [31:0] AVS_READDATA_OUT,
   input wire logic AVS_WAITREQUEST_OUT,
   input wire logic [12:0] STACK_TOP_OUT,
   input wire logic STACK_PUSH_OUT,
   input wire logic WATCHDOG_CLEAR_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   wire logic acc;
   wire logic rd_ans;
   assign acc = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == OFS_INSTR
      && AVS_BYTEENABLE_IN[1:0] == 2'h3;
   assign rd_ans = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
   a_watchdog_pulse_cause: assert property (
      WATCHDOG_CLEAR_OUT == $past(acc && AVS_WRITEDATA_IN[13:0] == OPC_WATCHDOG_CLEAR))
      else $error("watchdog clear pulse without its instruction");
   a_push_follows_call: assert property (
      STACK_PUSH_OUT == $past(acc && (AVS_WRITEDATA_IN[13:0] & MSK_CALL) == OPC_CALL))
      else $error("push pulse does not match call");
   a_stack_top_moves: assert property ($changed(STACK_TOP_OUT) |-> STACK_PUSH_OUT)
      else $error("stack top changed without push");
   a_call_two_cycles: assert property (
      acc && (AVS_WRITEDATA_IN[13:0] & MSK_CALL) == OPC_CALL |=> AVS_WAITREQUEST_OUT [*2])
      else $error("call finished in one cycle");
   a_wait_one_cycle: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
      else $error("waitrequest low for more than one cycle");
   a_wait_bounded: assert property (
      (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |-> ##[0:8] !AVS_WAITREQUEST_OUT)
      else $error("bus request not answered");
   a_unmapped_zero: assert property (
      rd_ans && AVS_ADDRESS_IN > OFS_FILE_DATA |-> AVS_READDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   a_status_idle: assert property (
      rd_ans && AVS_ADDRESS_IN == OFS_STATUS |-> AVS_READDATA_OUT[31:3] == 29'h0)
      else $error("status read shows busy or upper bits");
endmodule
bind cise_core cise_core_properties i_props (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
   .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
   .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
   .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .STACK_TOP_OUT(STACK_TOP_OUT), .STACK_PUSH_OUT(STACK_PUSH_OUT),
   .WATCHDOG_CLEAR_OUT(WATCHDOG_CLEAR_OUT));
`default_nettype wire

/* bench/cise_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cise_core_tb
   import cise_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic wait_req;
   logic [12:0] stack_top;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   cise_core i_dut (.CLK_IN(clk), .RSTN_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .STACK_TOP_OUT(stack_top),
      .STACK_PUSH_OUT(), .WATCHDOG_CLEAR_OUT());
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   // Request held until waitrequest is sampled low; one idle edge before the next
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] b, output logic [31:0] q);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      be <= b;
      do @(posedge clk); while (wait_req !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, 4'hF, q);
   endtask
   task automatic chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, 4'hF, q);
      cmp(q, exp);
   endtask
   task automatic t_op(input logic [13:0] op, input logic [6:0] f, input logic [7:0] init,
      input logic z0, input logic [7:0] ew, input logic [7:0] ef, input logic ez,
      input logic [12:0] epc);
      wr_reg(OFS_PC, 32'h100);
      wr_reg(OFS_WORK, 32'hAA);
      wr_reg(OFS_STATUS, 32'(3'h6 | 3'(z0)));
      wr_reg(OFS_FILE_PTR, 32'(f));
      wr_reg(OFS_FILE_DATA, 32'(init));
      wr_reg(OFS_INSTR, 32'(op | 14'(f)));
      chk(OFS_WORK, 32'(ew));
      chk(OFS_FILE_DATA, 32'(ef));
      chk(OFS_STATUS, 32'(3'h6 | 3'(ez)));
      chk(OFS_PC, 32'(epc));
      $display("op %h done", op);
   endtask
   task automatic t_reset;
      chk(OFS_STATUS, 32'h6);
      chk(OFS_PC, 32'h0);
      chk(OFS_WORK, 32'h0);
      chk(OFS_STACK_TOP, 32'h0);
      $display("reset values done");
   endtask
   task automatic t_watchdog;
      logic [31:0] q;
      repeat (600) @(posedge clk);
      xfer(1'b0, OFS_WATCHDOG, 32'h0, 4'hF, q);
      cmp(32'(q[7:0] != 8'h0), 32'h1);
      wr_reg(OFS_STATUS, 32'h1);
      xfer(1'b1, OFS_INSTR, 32'(OPC_WATCHDOG_CLEAR), 4'hC, q);
      chk(OFS_STATUS, 32'h1); // Narrow lanes issue nothing
      wr_reg(OFS_INSTR, 32'(OPC_WATCHDOG_CLEAR));
      chk(OFS_STATUS, 32'h7);
      xfer(1'b0, OFS_WATCHDOG, 32'h0, 4'hF, q);
      cmp(32'(q[31:12] == 20'h0 && q[7:0] == 8'h0), 32'h1);
      $display("watchdog clear done");
   endtask
   task automatic t_call;
      wr_reg(OFS_PC, 32'h0123);
      wr_reg(OFS_PC_HIGH_LATCH, 32'h0A);
      wr_reg(OFS_STATUS, 32'h1);
      wr_reg(OFS_INSTR, 32'h2555);
      chk(OFS_PC, 32'h0D55);
      chk(OFS_STACK_TOP, 32'h0124);
      cmp(32'(stack_top), 32'h0124);
      chk(OFS_STATUS, 32'h1);
      $display("call done");
   endtask
   task automatic t_unmapped;
      for (int a = 9; a < 16; a++) begin
         wr_reg(4'(a), 32'hFFFF_FFFF);
         chk(4'(a), 32'h0);
      end
      $display("unmapped done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_watchdog();
      t_call();
      t_op(14'h0380, 7'h7F, 8'h01, 1'b0, 8'hAA, 8'h00, 1'b1, 13'h101);
      t_op(14'h0300, 7'h00, 8'h00, 1'b1, 8'hFF, 8'h00, 1'b0, 13'h101);
      t_op(14'h0980, 7'h40, 8'hFF, 1'b0, 8'hAA, 8'h00, 1'b1, 13'h101);
      t_op(14'h0900, 7'h05, 8'h5A, 1'b1, 8'hA5, 8'h5A, 1'b0, 13'h101);
      t_op(14'h0180, 7'h10, 8'h33, 1'b0, 8'hAA, 8'h00, 1'b1, 13'h101);
      t_op(14'h0100, 7'h7F, 8'h44, 1'b0, 8'h00, 8'h44, 1'b1, 13'h101);
      t_op(14'h0B80, 7'h20, 8'h02, 1'b1, 8'hAA, 8'h01, 1'b1, 13'h101);
      t_op(14'h0B00, 7'h21, 8'h01, 1'b0, 8'h00, 8'h01, 1'b0, 13'h102);
      t_unmapped();
      print_verdict();
   end
endmodule
`default_nettype wire
